// [hdl/adcri_pkg.sv]
package adcri_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [13:0] IDX_RESULT_LOW      = 14'h0508;
    localparam logic [13:0] IDX_RESULT_HIGH     = 14'h0509;
    localparam logic [13:0] IDX_EN_MAIN         = 14'h050C;
    localparam logic [13:0] IDX_EN_CHAN_HIGH    = 14'h050D;
    localparam logic [13:0] IDX_EN_CHAN_LOW     = 14'h050E;
    localparam logic [13:0] IDX_EN_SELFTEST     = 14'h050F;
    localparam logic [13:0] IDX_FLAG_MAIN       = 14'h0510;
    localparam logic [13:0] IDX_FLAG_CHAN_HIGH  = 14'h0511;
    localparam logic [13:0] IDX_FLAG_CHAN_LOW   = 14'h0512;
    localparam logic [13:0] IDX_FLAG_SELFTEST   = 14'h0513;
    localparam logic [13:0] IDX_CONTROL         = 14'h0530;

    // main flag / enable bit positions
    localparam int BIT_CONV_DONE     = 0;
    localparam int BIT_READY         = 1;
    localparam int BIT_SUM_HIGH      = 2;
    localparam int BIT_SUM_LOW       = 3;
    localparam int BIT_TEMP_EXPIRED  = 5;
    localparam int BIT_OVERRANGE     = 6;
    localparam int BIT_CAL_COMPLETE  = 7;

    // result-high and control fields
    localparam int BIT_CAL_BYPASS    = 7;
    localparam int BIT_CONV_START    = 0;
    localparam int BIT_REF_EXTERNAL  = 1;
    localparam int BIT_GLOBAL_IRQ_EN = 2;

    // self-test fields
    localparam int BIT_ST_TEMP_ERR   = 1;
    localparam int BIT_ST_LIMIT_LO   = 3;

    // writable / implemented bit masks
    localparam logic [7:0] MASK_MAIN     = 8'hEF;
    localparam logic [7:0] MASK_SELFTEST = 8'h7A;
    localparam logic [7:0] MASK_CONTROL  = 8'h07;
    localparam logic [7:0] RESET_BYTE    = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // events from the converter and monitors, one-cycle pulses
    typedef struct packed {
        logic       conv_done;
        logic [9:0] raw_result;
        logic [9:0] corrected_result;
        logic       ready;
        logic       overrange;
        logic       cal_complete;
        logic       temp_cal_expired;
        logic [7:0] chan_high;
        logic [7:0] chan_low;
        logic [3:0] selftest_limit;
        logic       temp_sensor_error;
    } adcri_evt_t;

    // control levels towards the analogue side
    typedef struct packed {
        logic conv_start;
        logic ref_external;
        logic calibration_bypass;
    } adcri_ctrl_t;

endpackage

// [hdl/adcri_regs.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module adcri_regs
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [15:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [15:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire adcri_pkg::adcri_evt_t evt,
    output adcri_pkg::adcri_ctrl_t    ctrl,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] awaddr_reg;
    logic        aw_have_reg;
    logic [7:0]  wbyte_reg;
    logic        wstrb0_reg;
    logic        w_have_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic [9:0]  result_reg;
    logic        bypass_reg;
    logic [7:0]  en_main_reg;
    logic [7:0]  en_high_reg;
    logic [7:0]  en_low_reg;
    logic [7:0]  en_st_reg;
    logic [7:0]  flag_main_reg;
    logic [7:0]  flag_high_reg;
    logic [7:0]  flag_low_reg;
    logic [7:0]  flag_st_reg;
    logic [7:0]  control_reg;
    logic        irq_reg;

    logic [7:0]  flag_main_next;
    logic [7:0]  flag_high_next;
    logic [7:0]  flag_low_next;
    logic [7:0]  flag_st_next;
    logic [7:0]  control_next;
    logic        irq_next;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes; one write and one read in flight at most
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire wr_fire  = aw_have_reg && w_have_reg;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // write decode; misaligned addresses fall through as unmapped
    wire [13:0] widx     = awaddr_reg[15:2];
    wire        waligned = (awaddr_reg[1:0] == 2'b00);
    wire        wsel_rh  = waligned && (widx == adcri_pkg::IDX_RESULT_HIGH);
    wire        wsel_em  = waligned && (widx == adcri_pkg::IDX_EN_MAIN);
    wire        wsel_eh  = waligned && (widx == adcri_pkg::IDX_EN_CHAN_HIGH);
    wire        wsel_el  = waligned && (widx == adcri_pkg::IDX_EN_CHAN_LOW);
    wire        wsel_es  = waligned && (widx == adcri_pkg::IDX_EN_SELFTEST);
    wire        wsel_ct  = waligned && (widx == adcri_pkg::IDX_CONTROL);
    // read-only and flag registers accept a write harmlessly
    wire        wsel_ro  = waligned && ((widx == adcri_pkg::IDX_RESULT_LOW)
                           || (widx >= adcri_pkg::IDX_FLAG_MAIN
                               && widx <= adcri_pkg::IDX_FLAG_SELFTEST));
    wire        wmapped  = wsel_rh || wsel_em || wsel_eh || wsel_el || wsel_es
                           || wsel_ct || wsel_ro;
    wire        wr_do    = wr_fire && wstrb0_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read decode
    wire [13:0] ridx     = s_axi_araddr[15:2];
    wire        raligned = (s_axi_araddr[1:0] == 2'b00);
    wire        rsel_rl  = raligned && (ridx == adcri_pkg::IDX_RESULT_LOW);
    wire        rsel_rh  = raligned && (ridx == adcri_pkg::IDX_RESULT_HIGH);
    wire        rsel_em  = raligned && (ridx == adcri_pkg::IDX_EN_MAIN);
    wire        rsel_eh  = raligned && (ridx == adcri_pkg::IDX_EN_CHAN_HIGH);
    wire        rsel_el  = raligned && (ridx == adcri_pkg::IDX_EN_CHAN_LOW);
    wire        rsel_es  = raligned && (ridx == adcri_pkg::IDX_EN_SELFTEST);
    wire        rsel_fm  = raligned && (ridx == adcri_pkg::IDX_FLAG_MAIN);
    wire        rsel_fh  = raligned && (ridx == adcri_pkg::IDX_FLAG_CHAN_HIGH);
    wire        rsel_fl  = raligned && (ridx == adcri_pkg::IDX_FLAG_CHAN_LOW);
    wire        rsel_fs  = raligned && (ridx == adcri_pkg::IDX_FLAG_SELFTEST);
    wire        rsel_ct  = raligned && (ridx == adcri_pkg::IDX_CONTROL);
    wire        rmapped  = rsel_rl || rsel_rh || rsel_em || rsel_eh || rsel_el
                           || rsel_es || rsel_fm || rsel_fh || rsel_fl || rsel_fs
                           || rsel_ct;

    // read mux; flags are returned as they stood before the clear
    wire [7:0] rbyte =
          rsel_rl ? result_reg[7:0]
        : rsel_rh ? {bypass_reg, 5'b00000, result_reg[9:8]}
        : rsel_em ? en_main_reg
        : rsel_eh ? en_high_reg
        : rsel_el ? en_low_reg
        : rsel_es ? en_st_reg
        : rsel_fm ? flag_main_reg
        : rsel_fh ? flag_high_reg
        : rsel_fl ? flag_low_reg
        : rsel_fs ? flag_st_reg
        : rsel_ct ? control_reg
        : adcri_pkg::RESET_BYTE;

    // a taken read of a flag register clears every bit of it
    wire clr_main = ar_take && rsel_fm;
    wire clr_high = ar_take && rsel_fh;
    wire clr_low  = ar_take && rsel_fl;
    wire clr_st   = ar_take && rsel_fs;

    ////////////////////////////////////////////////////////////////////////////
    // event vectors; a new event in the clearing cycle survives
    wire [7:0] main_evt;
    assign main_evt[adcri_pkg::BIT_CONV_DONE]    = evt.conv_done;
    assign main_evt[adcri_pkg::BIT_READY]        = evt.ready;
    assign main_evt[adcri_pkg::BIT_SUM_HIGH]     = |evt.chan_high;
    assign main_evt[adcri_pkg::BIT_SUM_LOW]      = |evt.chan_low;
    assign main_evt[4]                           = 1'b0;
    assign main_evt[adcri_pkg::BIT_TEMP_EXPIRED] = evt.temp_cal_expired;
    assign main_evt[adcri_pkg::BIT_OVERRANGE]    = evt.overrange;
    assign main_evt[adcri_pkg::BIT_CAL_COMPLETE] = evt.cal_complete;

    wire [7:0] st_evt = {1'b0, evt.selftest_limit, 1'b0, evt.temp_sensor_error, 1'b0};

    assign flag_main_next = ((clr_main ? 8'h00 : flag_main_reg) | main_evt)
                            & adcri_pkg::MASK_MAIN;
    assign flag_high_next = (clr_high ? 8'h00 : flag_high_reg) | evt.chan_high;
    assign flag_low_next  = (clr_low ? 8'h00 : flag_low_reg) | evt.chan_low;
    assign flag_st_next   = ((clr_st ? 8'h00 : flag_st_reg) | st_evt)
                            & adcri_pkg::MASK_SELFTEST;

    ////////////////////////////////////////////////////////////////////////////
    // control: software start wins over the completion clear
    wire wr_ct = wr_do && wsel_ct;
    assign control_next = wr_ct ? (wbyte_reg & adcri_pkg::MASK_CONTROL)
        : (control_reg & ~({7'b0000000, evt.conv_done}));

    assign ctrl.conv_start         = control_reg[adcri_pkg::BIT_CONV_START];
    assign ctrl.ref_external       = control_reg[adcri_pkg::BIT_REF_EXTERNAL];
    assign ctrl.calibration_bypass = bypass_reg;
    wire   global_en = control_reg[adcri_pkg::BIT_GLOBAL_IRQ_EN];

    ////////////////////////////////////////////////////////////////////////////
    // interrupt products
    wire main_hit = |(flag_main_reg & en_main_reg);
    wire high_hit = en_main_reg[adcri_pkg::BIT_SUM_HIGH]
                    && |(flag_high_reg & en_high_reg);
    wire low_hit  = en_main_reg[adcri_pkg::BIT_SUM_LOW]
                    && |(flag_low_reg & en_low_reg);
    wire st_hit   = |(flag_st_reg & en_st_reg);
    assign irq_next = global_en && (main_hit || high_hit || low_hit || st_hit);
    assign irq      = irq_reg;

    // raw output when bypassing correction
    wire [9:0] result_sel = bypass_reg ? evt.raw_result : evt.corrected_result;

    ////////////////////////////////////////////////////////////////////////////
    // write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 16'h0000;
            wbyte_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= adcri_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awaddr_reg <= s_axi_awaddr;
            if (w_take)
            begin
                wbyte_reg  <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            aw_have_reg <= wr_fire ? 1'b0 : (aw_have_reg || aw_take);
            w_have_reg  <= wr_fire ? 1'b0 : (w_have_reg || w_take);
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wmapped ? adcri_pkg::RESP_OKAY : adcri_pkg::RESP_DECERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // read response, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= adcri_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rbyte};
            rresp_reg  <= rmapped ? adcri_pkg::RESP_OKAY : adcri_pkg::RESP_DECERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // enables and bypass; reserved bits never store
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_main_reg <= adcri_pkg::RESET_BYTE;
            en_high_reg <= adcri_pkg::RESET_BYTE;
            en_low_reg  <= adcri_pkg::RESET_BYTE;
            en_st_reg   <= adcri_pkg::RESET_BYTE;
            bypass_reg  <= 1'b0;
        end
        else if (wr_do)
        begin
            if (wsel_em)
                en_main_reg <= wbyte_reg & adcri_pkg::MASK_MAIN;
            if (wsel_eh)
                en_high_reg <= wbyte_reg;
            if (wsel_el)
                en_low_reg  <= wbyte_reg;
            if (wsel_es)
                en_st_reg   <= wbyte_reg & adcri_pkg::MASK_SELFTEST;
            if (wsel_rh)
                bypass_reg  <= wbyte_reg[adcri_pkg::BIT_CAL_BYPASS];
        end
    end

    // flags, result, control and the registered interrupt level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_main_reg <= adcri_pkg::RESET_BYTE;
            flag_high_reg <= adcri_pkg::RESET_BYTE;
            flag_low_reg  <= adcri_pkg::RESET_BYTE;
            flag_st_reg   <= adcri_pkg::RESET_BYTE;
            control_reg   <= adcri_pkg::RESET_BYTE;
            result_reg    <= 10'h000;
            irq_reg       <= 1'b0;
        end
        else
        begin
            flag_main_reg <= flag_main_next;
            flag_high_reg <= flag_high_next;
            flag_low_reg  <= flag_low_next;
            flag_st_reg   <= flag_st_next;
            control_reg   <= control_next;
            irq_reg       <= irq_next;
            if (evt.conv_done)
                result_reg <= result_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_main_read_quiet;
        clr_main && (main_evt == 8'h00);
    endsequence

    // a completion with no control write in the same cycle
    sequence seq_done_no_write;
        evt.conv_done && !wr_ct;
    endsequence

    AST_RESULT_LOW: assert property (evt.conv_done
        |=> result_reg[7:0] == $past(result_sel[7:0]))
        else $error("result low byte not captured");
    AST_RESULT_HIGH: assert property (ar_take && rsel_rh
        |=> rdata_reg[1:0] == $past(result_reg[9:8]))
        else $error("result high bits wrong on read");
    AST_BYPASS_RAW: assert property (evt.conv_done && bypass_reg
        |=> result_reg == $past(evt.raw_result))
        else $error("bypass did not deliver raw result");
    AST_BYPASS_READ: assert property (ar_take && rsel_rh
        |=> rdata_reg[7] == $past(bypass_reg))
        else $error("bypass bit wrong on read");
    AST_DONE_SET: assert property (evt.conv_done
        |=> flag_main_reg[0] && ctrl.conv_start == ($past(wr_ct) && $past(wbyte_reg[0])))
        else $error("conversion done handling wrong");
    AST_START_CLEAR: assert property (seq_done_no_write |=> !ctrl.conv_start)
        else $error("conversion start not cleared on completion");
    AST_MAIN_CLEAR: assert property (seq_main_read_quiet |=> flag_main_reg == 8'h00)
        else $error("main flags not cleared by read");
    AST_READY_SET: assert property (evt.ready |=> flag_main_reg[1])
        else $error("ready flag not set");
    AST_SUMMARY: assert property (|evt.chan_low
        |=> flag_main_reg[3] && flag_low_reg != 8'h00)
        else $error("summary low flag not set");
    AST_OVR_SET: assert property (evt.overrange |=> flag_main_reg[6])
        else $error("overrange flag not set");
    AST_CAL_SET: assert property (evt.cal_complete |=> flag_main_reg[7])
        else $error("calibration flag not set");
    AST_EXPIRED: assert property (evt.temp_cal_expired |=> flag_main_reg[5])
        else $error("expiry flag not set");
    AST_CHAN_SET: assert property (|evt.chan_high
        |=> (flag_high_reg & $past(evt.chan_high)) == $past(evt.chan_high))
        else $error("channel high flag not set");
    AST_CHAN_CLEAR: assert property (clr_high && evt.chan_high == 8'h00
        |=> flag_high_reg == 8'h00)
        else $error("channel high flags not cleared");
    AST_RESV_EN: assert property (en_main_reg[4] == 1'b0 && en_st_reg[2] == 1'b0)
        else $error("reserved enable bit stored");
    AST_NO_GLOBAL: assert property (!global_en |=> !irq)
        else $error("irq without global enable");
    AST_CHAN_IRQ: assert property (global_en && en_main_reg[2]
        && |(flag_high_reg & en_high_reg) |=> irq)
        else $error("channel high irq missing");
    AST_LOW_IRQ: assert property (global_en && en_main_reg[3]
        && |(flag_low_reg & en_low_reg) |=> irq)
        else $error("channel low irq missing");
    AST_ST_IRQ: assert property (global_en && |(flag_st_reg & en_st_reg) |=> irq)
        else $error("self-test irq missing");
    AST_ST_SET: assert property (evt.selftest_limit[3] |=> flag_st_reg[6])
        else $error("self-test limit flag not set");
    AST_TEMP_ERR: assert property (evt.temp_sensor_error |=> flag_st_reg[1])
        else $error("sensor error flag not set");
    // the level trails the flags by one edge, so look one cycle back for the cause
    AST_HOLD_IRQ: assert property (irq && !$past(ar_take) && !$past(wr_do) |=> irq)
        else $error("irq dropped without read or write");

endmodule

// [testbench/adc_result_and_irq_regs_bench.sv]
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end

module adc_result_and_irq_regs_bench;

    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [15:0]            awaddr, araddr;
    logic [31:0]            wdata, rdata, rv;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp, rr;
    logic                   awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready, irq;
    logic [7:0]             en;
    logic [9:0]             raw, cor, ex;
    adcri_pkg::adcri_evt_t  evt, e;
    adcri_pkg::adcri_ctrl_t ctrl;
    int                     num_errors, n_checks, cyc, c, s, bt;

    ////////////////////////////////////////////////////////////////////////////
    // device under test, every input driven by the bench
    adcri_regs i_dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .evt(evt), .ctrl(ctrl), .irq(irq)
    );

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [13:0] idx, input logic [7:0] v, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask

    task automatic rd(input logic [13:0] idx, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [13:0] idx, input logic [7:0] x);
        rd(idx, rv, rr);
        `CHK(rv, {24'h00_0000, x})
        `CHK(rr, adcri_pkg::RESP_OKAY)
    endtask

    // one-cycle event pulse
    task automatic pulse(input adcri_pkg::adcri_evt_t p);
        @(posedge aclk);
        evt <= p;
        @(posedge aclk);
        evt <= '0;
    endtask

    // irq is registered one edge behind the flag, so two edges settle it
    task automatic irqchk(input logic x);
        repeat (2) @(posedge aclk);
        #1;
        `CHK(irq, x)
    endtask

    function automatic logic [9:0] exp_result(input logic bp, input logic [9:0] rw,
                                              input logic [9:0] cr);
        return bp ? rw : cr;
    endfunction

    function automatic adcri_pkg::adcri_evt_t main_evt(input int b, input int ch);
        adcri_pkg::adcri_evt_t t;
        t = '0;
        case (b)
            0: t.conv_done = 1'b1;
            1: t.ready = 1'b1;
            2: t.chan_high[ch] = 1'b1;
            3: t.chan_low[ch] = 1'b1;
            5: t.temp_cal_expired = 1'b1;
            6: t.overrange = 1'b1;
            default: t.cal_complete = 1'b1;
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, map, conversion, flags, gating
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        evt = '0;
        {cyc, num_errors, n_checks} = '0;
        void'($urandom(32'h4e25_2724));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK(irq, 1'b0)
        for (int i = 0; i < 8; i++) rdchk(14'h050C + 14'(i), 8'h00);
        rdchk(adcri_pkg::IDX_RESULT_HIGH, 8'h00);
        // unmapped place refused both ways
        wr(14'h0600, 8'hFF, adcri_pkg::RESP_DECERR);
        rd(14'h0600, rv, rr);
        `CHK(rr, adcri_pkg::RESP_DECERR)
        wr(adcri_pkg::IDX_EN_MAIN, 8'hFF, adcri_pkg::RESP_OKAY);
        rdchk(adcri_pkg::IDX_EN_MAIN, 8'hEF);
        // byte lane 0 off: the write is answered but leaves the register alone
        wstrb <= 4'hE;
        wr(adcri_pkg::IDX_EN_MAIN, 8'h00, adcri_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rdchk(adcri_pkg::IDX_EN_MAIN, 8'hEF);
        en = 8'($urandom);
        wr(adcri_pkg::IDX_EN_SELFTEST, en, adcri_pkg::RESP_OKAY);
        rdchk(adcri_pkg::IDX_EN_SELFTEST, en & 8'h7A);
        // conversion with and without the bypass; read-only bits written as ones
        for (int bp = 0; bp < 2; bp++)
        begin
            // bypass first, so the external reference is never chosen without it
            wr(adcri_pkg::IDX_RESULT_HIGH, {bp[0], 7'h7F}, adcri_pkg::RESP_OKAY);
            wr(adcri_pkg::IDX_CONTROL, {6'b00_0001, bp[0], 1'b1}, adcri_pkg::RESP_OKAY);
            #1;
            `CHK(ctrl, {1'b1, bp[0], bp[0]})
            raw = 10'($urandom);
            cor = 10'($urandom);
            e = main_evt(0, 0);
            e.raw_result = raw;
            e.corrected_result = cor;
            pulse(e);
            @(posedge aclk);
            #1;
            `CHK(ctrl.conv_start, 1'b0)
            ex = exp_result(bp[0], raw, cor);
            rdchk(adcri_pkg::IDX_RESULT_LOW, ex[7:0]);
            rdchk(adcri_pkg::IDX_RESULT_HIGH, {bp[0], 5'h00, ex[9:8]});
            rdchk(adcri_pkg::IDX_FLAG_MAIN, 8'h01);
        end
        // each main source against a random enable
        for (int b = 0; b < 8; b++)
        begin
            if (b == 4) continue;
            en = 8'($urandom);
            // global enable drawn at random, forced off once as a corner
            s = (b == 0) ? 0 : $urandom_range(1);
            wr(adcri_pkg::IDX_CONTROL, 8'(2 + 4 * s), adcri_pkg::RESP_OKAY);
            wr(adcri_pkg::IDX_EN_MAIN, en, adcri_pkg::RESP_OKAY);
            pulse(main_evt(b, $urandom_range(7)));
            irqchk(en[b] & s[0]);
            rdchk(adcri_pkg::IDX_FLAG_MAIN, 8'(1 << b));
            rdchk(adcri_pkg::IDX_FLAG_MAIN, 8'h00);
            irqchk(1'b0);
        end
        // global enable back on for the channel and self-test groups
        wr(adcri_pkg::IDX_CONTROL, 8'h06, adcri_pkg::RESP_OKAY);
        rd(adcri_pkg::IDX_FLAG_CHAN_HIGH, rv, rr);
        rd(adcri_pkg::IDX_FLAG_CHAN_LOW, rv, rr);
        // channel sources need channel and summary enables
        for (int k = 0; k < 6; k++)
        begin
            c = $urandom_range(7);
            s = $urandom_range(1);
            en = 8'($urandom);
            wr(adcri_pkg::IDX_EN_CHAN_HIGH + k[0], en, adcri_pkg::RESP_OKAY);
            wr(adcri_pkg::IDX_EN_MAIN, 8'(s << (2 + k[0])), adcri_pkg::RESP_OKAY);
            e = '0;
            if (k[0]) e.chan_low[c] = 1'b1;
            else e.chan_high[c] = 1'b1;
            pulse(e);
            irqchk(s[0]);
            rdchk(adcri_pkg::IDX_FLAG_MAIN, 8'(1 << (2 + k[0])));
            irqchk(en[c] & s[0]);
            rdchk(adcri_pkg::IDX_FLAG_CHAN_HIGH + k[0], 8'(1 << c));
            irqchk(1'b0);
        end
        // self-test sources, one at a time
        for (int j = 0; j < 5; j++)
        begin
            en = 8'($urandom);
            bt = (j < 4) ? 3 + j : 1;
            wr(adcri_pkg::IDX_EN_SELFTEST, en, adcri_pkg::RESP_OKAY);
            e = '0;
            if (j < 4) e.selftest_limit[j] = 1'b1;
            else e.temp_sensor_error = 1'b1;
            pulse(e);
            irqchk(en[bt]);
            rdchk(adcri_pkg::IDX_FLAG_SELFTEST, 8'(1 << bt));
            irqchk(1'b0);
        end
        test_done();
    end

endmodule
